// ==== logic/fst_lut_entries.sv ====
// Fan speed table entries three and four: registers, readback and duty select
// Operation
// - Low-resolution temperature mode: limit top bit unused, reads as zero.
// - High-resolution temperature mode: eight limit bits, 0 to 127.5 degrees, half steps.
// - Low-resolution temperature mode: seven limit bits as whole degrees, 0 to 127.
// - Compare nine reading bits in high resolution, eight in low resolution.
// - Temperature above entry three limit, but not entry four, drives its duty value to the fan.
// - Temperature above entry four limit drives its duty value to the fan.
// - Every limit is positive; sign bit taken as zero.
// - Offset register value is added to entry limits to extend range.
// - Low-resolution duty mode: duty upper two bits unused, read as zero.
// - High-resolution duty mode: upper and lower bits form an eight-bit duty.
// - Extended duty bits act only with the 22.5 kHz fan PWM rate.
// - Low-resolution duty mode: six lower bits are the duty value.
// - Entries always readable; writes only while table write enable is set.
`timescale 1ns/100ps
module fst_lut_entries
    import fst_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr_en,
    input  wire logic [7:0]            reg_wr_data,
    input  wire logic                  reg_rd_en,
    output logic      [7:0]            reg_rd_data,
    output logic                       reg_rd_valid,
    input  wire logic                  table_write_enable,
    input  wire logic                  temp_hi_res,
    input  wire logic                  duty_hi_res,
    input  wire logic                  pwm_freq_22k5,
    input  wire logic [7:0]            table_offset,
    input  wire logic [FST_TEMP_W-1:0] remote_temp,
    input  wire logic                  remote_temp_valid,
    output logic      [7:0]            fan_duty,
    output logic                       fan_duty_active,
    output logic      [1:0]            entry_exceeded
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [FST_ENTRIES-1:0][7:0] limit;
        logic [FST_ENTRIES-1:0][7:0] duty;
        logic [7:0]                  rd_data;
        logic                        rd_valid;
        logic [7:0]                  fan_duty;
        logic                        active;
        logic [1:0]                  exceeded;
    } fst_state_t;

    fst_state_t state_reg;
    fst_state_t state_next;

    logic [FST_ENTRIES-1:0]      cmp_hit;
    logic [FST_ENTRIES-1:0][7:0] duty_eff;
    logic [FST_ENTRIES-1:0][7:0] limit_rd;
    logic [FST_ENTRIES-1:0][7:0] duty_rd;

    // ------------------------------------------------------------
    // Per-entry compare and field views
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < FST_ENTRIES; gi++) begin : g_entry
            fst_entry_cmp u_cmp (
                .limit_byte   (state_reg.limit[gi]),
                .table_offset (table_offset),
                .remote_temp  (remote_temp),
                .temp_hi_res  (temp_hi_res),
                .exceeded     (cmp_hit[gi])
            );

            always_comb begin
                limit_rd[gi] = temp_hi_res ? state_reg.limit[gi]
                             : {1'b0, state_reg.limit[gi][FST_LIMIT_LOW_MSB:0]};
                duty_rd[gi]  = duty_hi_res ? state_reg.duty[gi]
                             : {2'b00, state_reg.duty[gi][FST_DUTY_BASE_MSB:0]};
                // six-bit duty, eight-bit in high-resolution duty mode at 22.5 kHz
                // Stored upper bits are kept, so switching modes back restores them
                if (duty_hi_res && pwm_freq_22k5) begin
                    duty_eff[gi] = state_reg.duty[gi];
                end else begin
                    duty_eff[gi] = {2'b00, state_reg.duty[gi][FST_DUTY_BASE_MSB:0]};
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;

        if (reg_wr_en && table_write_enable) begin
            case (reg_addr)
                FST_OFS_ENTRY3_TEMP_LIMIT: begin
                    state_next.limit[0] = reg_wr_data;
                end
                FST_OFS_ENTRY3_DUTY: begin
                    state_next.duty[0] = reg_wr_data;
                end
                FST_OFS_ENTRY4_TEMP_LIMIT: begin
                    state_next.limit[1] = reg_wr_data;
                end
                FST_OFS_ENTRY4_DUTY: begin
                    state_next.duty[1] = reg_wr_data;
                end
                default: begin
                end
            endcase
        end

        if (reg_rd_en) begin
            state_next.rd_valid = 1'b1;
            case (reg_addr)
                FST_OFS_ENTRY3_TEMP_LIMIT: begin
                    state_next.rd_data = limit_rd[0];
                end
                FST_OFS_ENTRY3_DUTY: begin
                    state_next.rd_data = duty_rd[0];
                end
                FST_OFS_ENTRY4_TEMP_LIMIT: begin
                    state_next.rd_data = limit_rd[1];
                end
                FST_OFS_ENTRY4_DUTY: begin
                    state_next.rd_data = duty_rd[1];
                end
                default: begin
                    state_next.rd_data = FST_RD_UNMAPPED;
                end
            endcase
        end

        // evaluate on new result
        // Between results the output holds, so a limit write acts at the next result
        if (remote_temp_valid) begin
            state_next.exceeded = cmp_hit;
            state_next.active   = |cmp_hit;
            if (cmp_hit[1]) begin
                state_next.fan_duty = duty_eff[1];
            end else if (cmp_hit[0]) begin
                state_next.fan_duty = duty_eff[0];
            end else begin
                state_next.fan_duty = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg.limit    <= {FST_RST_TEMP_LIMIT, FST_RST_TEMP_LIMIT};
            state_reg.duty     <= {FST_RST_DUTY, FST_RST_DUTY};
            state_reg.rd_data  <= 8'h00;
            state_reg.rd_valid <= 1'b0;
            state_reg.fan_duty <= 8'h00;
            state_reg.active   <= 1'b0;
            state_reg.exceeded <= 2'h0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign reg_rd_data     = state_reg.rd_data;
    assign reg_rd_valid    = state_reg.rd_valid;
    assign fan_duty        = state_reg.fan_duty;
    assign fan_duty_active = state_reg.active;
    assign entry_exceeded  = state_reg.exceeded;

endmodule

// ==== logic/fst_pkg.sv ====
// Constants for the fan speed table slice holding entries three and four
package fst_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FST_OFS_ENTRY3_TEMP_LIMIT = 8'h54;
    localparam logic [7:0] FST_OFS_ENTRY3_DUTY       = 8'h55;
    localparam logic [7:0] FST_OFS_ENTRY4_TEMP_LIMIT = 8'h56;
    localparam logic [7:0] FST_OFS_ENTRY4_DUTY       = 8'h57;

    // ------------------------------------------------------------
    // Reset values and read answers
    // ------------------------------------------------------------
    localparam logic [7:0] FST_RST_TEMP_LIMIT = 8'h7F;
    localparam logic [7:0] FST_RST_DUTY       = 8'h3F;
    localparam logic [7:0] FST_RD_UNMAPPED    = 8'h00;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int FST_LIMIT_TOP_BIT   = 7;
    localparam int FST_LIMIT_LOW_MSB   = 6;
    localparam int FST_DUTY_EXT_MSB    = 7;
    localparam int FST_DUTY_EXT_LSB    = 6;
    localparam int FST_DUTY_BASE_MSB   = 5;
    localparam int FST_TEMP_W          = 11;
    localparam int FST_TEMP_HI_LSB     = 2;
    localparam int FST_TEMP_LO_LSB     = 3;
    localparam int FST_CMP_W           = 10;
    localparam int FST_ENTRIES         = 2;

endpackage

// ==== logic/fst_entry_cmp.sv ====
// One table entry: limit scaling, offset add and exceed comparison
`timescale 1ns/100ps
module fst_entry_cmp
    import fst_pkg::*;
(
    input  wire logic [7:0]            limit_byte,
    input  wire logic [7:0]            table_offset,
    input  wire logic [FST_TEMP_W-1:0] remote_temp,
    input  wire logic                  temp_hi_res,
    output logic                       exceeded
);

    logic [FST_CMP_W-1:0] limit_val;
    logic [FST_CMP_W-1:0] temp_val;

    always_comb begin
        if (temp_hi_res) begin
            // half degree
            // Top bit is the half-degree step below the seven whole-degree bits
            limit_val = FST_CMP_W'({limit_byte[FST_LIMIT_LOW_MSB:0], limit_byte[FST_LIMIT_TOP_BIT]})
                      + FST_CMP_W'({table_offset, 1'b0});
            temp_val  = FST_CMP_W'(remote_temp[FST_TEMP_W-1:FST_TEMP_HI_LSB]);
        end else begin
            limit_val = FST_CMP_W'(limit_byte[FST_LIMIT_LOW_MSB:0])
                      + FST_CMP_W'(table_offset);
            temp_val  = FST_CMP_W'(remote_temp[FST_TEMP_W-1:FST_TEMP_LO_LSB]);
        end
        exceeded = (temp_val > limit_val);
    end

endmodule

// ==== verification/fst_lut_checker.sv ====
// Assertion checker for the fan speed table entries three and four
`timescale 1ns/100ps
module fst_lut_checker
    import fst_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  clk_en,
    input wire logic [7:0]            reg_addr,
    input wire logic                  reg_wr_en,
    input wire logic [7:0]            reg_wr_data,
    input wire logic                  reg_rd_en,
    input wire logic [7:0]            reg_rd_data,
    input wire logic                  reg_rd_valid,
    input wire logic                  table_write_enable,
    input wire logic                  temp_hi_res,
    input wire logic                  duty_hi_res,
    input wire logic                  pwm_freq_22k5,
    input wire logic [7:0]            table_offset,
    input wire logic [FST_TEMP_W-1:0] remote_temp,
    input wire logic                  remote_temp_valid,
    input wire logic [7:0]            fan_duty,
    input wire logic                  fan_duty_active,
    input wire logic [1:0]            entry_exceeded
);
    logic rd;
    logic tv;
    logic hit_a;
    assign rd    = clk_en && reg_rd_en;
    assign tv    = clk_en && remote_temp_valid;
    assign hit_a = reg_addr[7:2] == 6'h15;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_rd_lat; rd |=> reg_rd_valid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
    // Only an enabled cycle may end the valid pulse; a frozen cycle keeps it
    property p_rd_hold; clk_en && !reg_rd_en |=> !reg_rd_valid && $stable(reg_rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_freeze;
        !clk_en |=> $stable(reg_rd_valid) && $stable(reg_rd_data) && $stable(fan_duty);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    property p_lim_mask; rd && hit_a && !reg_addr[0] && !temp_hi_res |=> !reg_rd_data[7]; endproperty
    a_lim_mask: assert property (p_lim_mask) else $error("limit top bit set");
    property p_duty_mask; rd && hit_a && reg_addr[0] && !duty_hi_res |=> reg_rd_data[7:6] == 2'b00;
    endproperty
    a_duty_mask: assert property (p_duty_mask) else $error("duty upper bits set");
    property p_unmap; rd && !hit_a |=> reg_rd_data == FST_RD_UNMAPPED; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_act; fan_duty_active == (entry_exceeded != 2'b00); endproperty
    a_act: assert property (p_act) else $error("active flag wrong");
    property p_hold; !tv |=> $stable(fan_duty) && $stable(entry_exceeded); endproperty
    a_hold: assert property (p_hold) else $error("duty moved without result");
    property p_ext; tv && !(duty_hi_res && pwm_freq_22k5) |=> fan_duty[7:6] == 2'b00; endproperty
    a_ext: assert property (p_ext) else $error("extended duty bits used");
    property p_cold;
        tv && (remote_temp[10:2] == 9'h000 || (!temp_hi_res && remote_temp[10:3] == 8'h00))
        |=> entry_exceeded == 2'b00 && fan_duty == 8'h00;
    endproperty
    a_cold: assert property (p_cold) else $error("zero reading exceeded");
    c_both: cover property (tv ##1 entry_exceeded == 2'b11);
    c_unmap: cover property (rd && !hit_a);
    c_ext: cover property (tv ##1 fan_duty[7:6] != 2'b00);
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the fan speed table entries three and four
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module testbench
    import fst_pkg::*;
;
    logic                  ref_clk, reset, clk_en, reg_wr_en, reg_rd_en, reg_rd_valid;
    logic                  table_write_enable, temp_hi_res, duty_hi_res, pwm_freq_22k5;
    logic                  remote_temp_valid, fan_duty_active;
    logic [7:0]            reg_addr, reg_wr_data, reg_rd_data, table_offset, fan_duty;
    logic [FST_TEMP_W-1:0] remote_temp;
    logic [1:0]            entry_exceeded;
    logic [7:0]            lim [2];
    logic [7:0]            duty [2];
    int                    miscompares, checks, k, tv;
    fst_lut_entries dut_u (.ref_clk, .reset, .clk_en, .reg_addr, .reg_wr_en, .reg_wr_data,
        .reg_rd_en, .reg_rd_data, .reg_rd_valid, .table_write_enable, .temp_hi_res,
        .duty_hi_res, .pwm_freq_22k5, .table_offset, .remote_temp, .remote_temp_valid,
        .fan_duty, .fan_duty_active, .entry_exceeded);
    function automatic logic [7:0] rd_exp(input logic [7:0] a);
        if (a[7:2] != 6'h15) return 8'h00;
        if (a[0]) return duty_hi_res ? duty[a[1]] : {2'b00, duty[a[1]][5:0]};
        return temp_hi_res ? lim[a[1]] : {1'b0, lim[a[1]][6:0]};
    endfunction
    function automatic logic hit(input int i);
        if (temp_hi_res)
            return {1'b0, remote_temp[10:2]} > {2'b00, lim[i][6:0], lim[i][7]} + {1'b0, table_offset, 1'b0};
        return {2'b00, remote_temp[10:3]} > {3'b000, lim[i][6:0]} + {2'b00, table_offset};
    endfunction
    function automatic logic [7:0] dsel(input int i);
        return (duty_hi_res && pwm_freq_22k5) ? duty[i] : {2'b00, duty[i][5:0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ce);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        clk_en <= ce;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        clk_en <= 1'b1;
        if (ce && table_write_enable && a[7:2] == 6'h15 && a[0]) duty[a[1]] = d;
        if (ce && table_write_enable && a[7:2] == 6'h15 && !a[0]) lim[a[1]] = d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1;
        `CHK(reg_rd_valid, 1'b1)
        `CHK(reg_rd_data, rd_exp(a))
    endtask
    task automatic cmp(input logic [10:0] t);
        logic [1:0] ex;
        @(posedge ref_clk);
        remote_temp <= t;
        remote_temp_valid <= 1'b1;
        @(posedge ref_clk);
        remote_temp_valid <= 1'b0;
        #1;
        ex = {hit(1), hit(0)};
        `CHK(entry_exceeded, ex)
        `CHK(fan_duty, ex[1] ? dsel(1) : (ex[0] ? dsel(0) : 8'h00))
        `CHK(fan_duty_active, |ex)
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (50000) @(posedge ref_clk);
        miscompares++;
        complete_run;
    end
    initial begin
        {reset, clk_en, temp_hi_res, duty_hi_res, table_write_enable} = 5'h1F;
        {reg_wr_en, reg_rd_en, remote_temp_valid, pwm_freq_22k5} = 4'h0;
        {reg_addr, reg_wr_data, table_offset, remote_temp} = '0;
        lim = '{8'h7F, 8'h7F};
        duty = '{8'h3F, 8'h3F};
        void'($urandom(9));
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        // Reset values, unmapped neighbours and a write while protected
        for (int a = 8'h53; a <= 8'h58; a++) rd(8'(a));
        @(posedge ref_clk);
        table_write_enable <= 1'b0;
        wr(8'h54, 8'h00, 1'b1);
        rd(8'h54);
        for (int n = 0; n < 400; n++) begin
            @(posedge ref_clk);
            {temp_hi_res, duty_hi_res, pwm_freq_22k5} <= 3'($urandom);
            table_write_enable <= ($urandom % 8) != 0;
            table_offset <= (n % 4 == 0) ? 8'($urandom) : 8'($urandom % 16);
            wr(8'h53 + 8'($urandom % 6), 8'($urandom), ($urandom % 8) != 0);
            rd(8'h53 + 8'($urandom % 6));
            // Aim near a threshold so equal-to-limit cases show up
            k = $urandom % 2;
            tv = (lim[k][6:0] + table_offset) * 8 + $urandom % 24 - 12;
            cmp((n % 5 == 0) ? 11'($urandom) : 11'(tv));
        end
        // Mid-run reset puts entries and outputs back to their reset values
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK({fan_duty, fan_duty_active, entry_exceeded, reg_rd_valid}, 12'h000)
        reset <= 1'b0;
        {temp_hi_res, duty_hi_res} <= 2'b11;
        lim = '{8'h7F, 8'h7F};
        duty = '{8'h3F, 8'h3F};
        for (int a = 8'h54; a <= 8'h57; a++) rd(8'(a));
        // Coldest and hottest readings at both ends of the range
        cmp(11'h000);
        cmp(11'h7FF);
        complete_run;
    end
endmodule
bind fst_lut_entries fst_lut_checker chk_u (.ref_clk, .reset, .clk_en, .reg_addr, .reg_wr_en,
    .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid, .table_write_enable, .temp_hi_res,
    .duty_hi_res, .pwm_freq_22k5, .table_offset, .remote_temp, .remote_temp_valid,
    .fan_duty, .fan_duty_active, .entry_exceeded);
